// ===== rtl/ext_mem_if.sv
/*
 * external memory port: routes external moves on-chip or off-chip and
 * runs the pin sequence on ports 4..1 in multiplexed or separate mode.
 * assumes the cpu holds a request until DONE; pins pass an input sync.
 */
// Contract
// - pins are owned only during an off-chip move, then released.
// - data pin drivers are off during a read, except the multiplexed address phase.
// - open-drain or push-pull mode is left to port registers.
// - page register gives upper address byte for short moves.
// - config bit 4 selects multiplexed (0) or separate (1) bus.
// - config bits 3-2 select the memory mode.
// - config bits 7 and 5 read zero, writes ignored.
// - multiplexed mode shares low address and data pins, drives latch strobe.
// - first phase holds latch strobe high with low address shown.
// - latch strobe fall starts data phase with read or write strobe.
// - separate mode drives address and data on own pins.
// - signals sit on ports 4, 3, 2 and 1.
// - split modes send low addresses on-chip, higher ones off-chip.
// - short moves leave upper lines undriven unless bank select.
// - fifo direct access maps packet ram over 0x0400-0x07ff.
// - off-chip access takes 4 cycles plus timing, 5 or 7 least.
`timescale 1ns/1ns
`default_nettype none
module ext_mem_if
	import ext_mem_pkg::*;
(
	// clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RSTN,
	// register port
	input  wire logic       SFR_WR,
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic [7:0] SFR_WDATA,
	output var  logic [7:0] SFR_RDATA,
	// cpu move request
	input  wire move_req_type MOVE_REQ,
	output logic            MOVE_DONE,
	output logic [7:0]      MOVE_RDATA,
	output logic            ROUTE_ONCHIP,
	output logic            ROUTE_FIFO,
	// port 4 data or address/data pins
	input  wire logic [7:0] P4_IN,
	output pin_byte_type    P4_PIN,
	// port 3 low address, port 2 high address
	output pin_byte_type    P3_PIN,
	output pin_byte_type    P2_PIN,
	// port 1 strobes: bit 7 write, bit 6 read, bit 3 latch
	output pin_byte_type    P1_PIN
);

	typedef struct packed {
		phase_type    phase;
		logic [3:0]   cnt;
		logic [7:0]   d_sync1;
		logic [7:0]   d_sync2;
		logic         done;
		logic [7:0]   rdata;
		logic         onchip;
		logic         fifo;
		pin_byte_type p4;
		pin_byte_type p3;
		pin_byte_type p2;
		pin_byte_type p1;
	} if_state_type;

	if_state_type s_r;
	if_state_type s_nxt;
	config_type   cfg;
	logic [7:0]   page;
	logic [15:0]  eff_addr;
	logic         hit_fifo;
	logic         hit_onchip;
	logic [3:0]   ale_cycles;

	ext_mem_regs u_regs (
		.clk   (CLOCK),
		.rst_n (RSTN),
		.wr    (SFR_WR),
		.addr  (SFR_ADDR),
		.wdata (SFR_WDATA),
		.rdata (SFR_RDATA),
		.cfg   (cfg),
		.page  (page)
	);

	// =====================================================
	// address decode
	always_comb
	begin
		// short moves take the page byte as high address
		eff_addr = MOVE_REQ.short_addr ? {page, MOVE_REQ.addr[7:0]} : MOVE_REQ.addr;
		// fifo window overrides every memory mode
		hit_fifo = cfg.fifo_direct_access_en && eff_addr >= FIFO_BASE
			&& eff_addr <= FIFO_LAST;
		// split modes compare against on-chip size
		case (cfg.memory_mode_select)
			MODE_ONCHIP:       hit_onchip = 1'b1;
			MODE_SPLIT_NOBANK: hit_onchip = eff_addr < ONCHIP_SIZE;
			MODE_SPLIT_BANK:   hit_onchip = eff_addr < ONCHIP_SIZE;
			MODE_OFFCHIP:      hit_onchip = 1'b0;
			default:           hit_onchip = 1'b1;
		endcase
		// pulse width is field value plus one
		ale_cycles = {2'b00, cfg.latch_pulse_width_sel} + 4'd1;
	end

	// =====================================================
	// pin sequencer
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.d_sync1 = P4_IN;
		s_nxt.d_sync2 = s_r.d_sync1;
		s_nxt.done = 1'b0;
		case (s_r.phase)
			ST_IDLE:
			begin
				if (MOVE_REQ.start && !s_r.done)
				begin
					s_nxt.onchip = hit_onchip || hit_fifo;
					s_nxt.fifo = hit_fifo;
					if (hit_onchip || hit_fifo)
						s_nxt.done = 1'b1;
					else
					begin
						// pins claimed for the off-chip move
						// port 1 strobes idle high, port 3 low address
						s_nxt.p1.out = 8'hff;
						// latch pin joins only in multiplexed mode
						s_nxt.p1.oe_n = 8'h3f;
						s_nxt.p3.out = eff_addr[7:0];
						s_nxt.p3.oe_n = cfg.bus_mux_select ? 8'h00 : 8'hff;
						// upper lines free for short moves without bank select
						s_nxt.p2.out = eff_addr[15:8];
						s_nxt.p2.oe_n = (MOVE_REQ.short_addr &&
							cfg.memory_mode_select != MODE_SPLIT_BANK) ? 8'hff : 8'h00;
						// config bit 4 picks the bus style
						if (!cfg.bus_mux_select)
						begin
							// latch strobe high with address shown
							s_nxt.p4.out = eff_addr[7:0];
							s_nxt.p4.oe_n = 8'h00;
							s_nxt.p1.out[3] = 1'b1;
							s_nxt.p1.oe_n[3] = 1'b0;
							s_nxt.cnt = ale_cycles;
							s_nxt.phase = ST_ALE_HIGH;
						end
						else
						begin
							// data on own pins, no latch
							s_nxt.p4.out = MOVE_REQ.wdata;
							s_nxt.p4.oe_n = MOVE_REQ.write ? 8'h00 : 8'hff;
							s_nxt.cnt = BASE_CYCLES - 4'd1;
							s_nxt.phase = ST_STROBE;
						end
					end
				end
			end
			ST_ALE_HIGH:
			begin
				s_nxt.cnt = s_r.cnt - 4'd1;
				if (s_r.cnt == 4'd1)
				begin
					// latch strobe falls, second phase begins
					s_nxt.p1.out[3] = 1'b0;
					s_nxt.cnt = ale_cycles;
					s_nxt.phase = ST_ALE_LOW;
				end
			end
			ST_ALE_LOW:
			begin
				s_nxt.cnt = s_r.cnt - 4'd1;
				if (s_r.cnt == 4'd1)
				begin
					// read releases the shared data pins
					s_nxt.p4.out = MOVE_REQ.wdata;
					s_nxt.p4.oe_n = MOVE_REQ.write ? 8'h00 : 8'hff;
					s_nxt.cnt = BASE_CYCLES - 4'd1;
					s_nxt.phase = ST_STROBE;
				end
			end
			ST_STROBE:
			begin
				// one strobe cycle plus four base cycles
				if (MOVE_REQ.write)
					s_nxt.p1.out[7] = 1'b0;
				else
					s_nxt.p1.out[6] = 1'b0;
				s_nxt.phase = ST_TAIL;
			end
			ST_TAIL:
			begin
				s_nxt.p1.out[7] = 1'b1;
				s_nxt.p1.out[6] = 1'b1;
				// two sync flops: the byte seen at the strobe edge arrives here
				if (s_r.cnt == BASE_CYCLES - 4'd3 && !MOVE_REQ.write)
					s_nxt.rdata = s_r.d_sync2;
				s_nxt.cnt = s_r.cnt - 4'd1;
				if (s_r.cnt == 4'd0)
				begin
					// release every pin back to latches and crossbar
					// only enables released, drive mode untouched
					s_nxt.p1.oe_n = 8'hff;
					s_nxt.p2.oe_n = 8'hff;
					s_nxt.p3.oe_n = 8'hff;
					s_nxt.p4.oe_n = 8'hff;
					s_nxt.done = 1'b1;
					s_nxt.phase = ST_IDLE;
				end
			end
			default: s_nxt.phase = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RSTN)
		begin
			s_r.phase  <= ST_IDLE;
			s_r.cnt    <= 4'h0;
			s_r.d_sync1 <= 8'h00;
			s_r.d_sync2 <= 8'h00;
			s_r.done   <= 1'b0;
			s_r.rdata  <= 8'h00;
			s_r.onchip <= 1'b0;
			s_r.fifo   <= 1'b0;
			s_r.p4     <= {8'h00, 8'hff};
			s_r.p3     <= {8'h00, 8'hff};
			s_r.p2     <= {8'h00, 8'hff};
			s_r.p1     <= {8'h00, 8'hff};
		end
		else
			s_r <= s_nxt;
	end

	assign MOVE_DONE    = s_r.done;
	assign MOVE_RDATA   = s_r.rdata;
	assign ROUTE_ONCHIP = s_r.onchip;
	assign ROUTE_FIFO   = s_r.fifo;
	assign P4_PIN = s_r.p4;
	assign P3_PIN = s_r.p3;
	assign P2_PIN = s_r.p2;
	assign P1_PIN = s_r.p1;

endmodule
`default_nettype wire

// ===== rtl/ext_mem_pkg.sv
/*
 * package of the external memory port block: register offsets, field
 * positions, reset values, timing counts and the struct types.
 * assumes a single 10 MHz system clock and an 8-bit register port.
 */
package ext_mem_pkg;

	// =====================================================
	// register map
	localparam logic [7:0] CONFIG_ADDR    = 8'h85;
	localparam logic [7:0] PAGE_ADDR      = 8'haa;
	localparam logic [7:0] CONFIG_RESET   = 8'h03;
	localparam logic [7:0] PAGE_RESET     = 8'h00;
	localparam logic [7:0] CONFIG_WMASK   = 8'h5f;
	localparam int         FIFO_DA_BIT    = 6;
	localparam int         MUX_SEL_BIT    = 4;
	localparam int         MODE_HI_BIT    = 3;
	localparam int         MODE_LO_BIT    = 2;
	localparam int         ALE_HI_BIT     = 1;
	localparam int         ALE_LO_BIT     = 0;

	// =====================================================
	// memory map
	localparam logic [15:0] ONCHIP_SIZE   = 16'h1000;
	localparam logic [15:0] FIFO_BASE     = 16'h0400;
	localparam logic [15:0] FIFO_LAST     = 16'h07ff;

	// =====================================================
	// timing in ns and system clock cycles
	localparam int CLK_NS          = 100;
	localparam int BASE_NS         = 400;
	localparam logic [3:0] BASE_CYCLES = 4'(BASE_NS / CLK_NS);

	typedef enum logic [1:0] {
		MODE_ONCHIP,
		MODE_SPLIT_NOBANK,
		MODE_SPLIT_BANK,
		MODE_OFFCHIP
	} mem_mode_type;

	typedef enum {
		ST_IDLE,
		ST_ALE_HIGH,
		ST_ALE_LOW,
		ST_STROBE,
		ST_TAIL
	} phase_type;

	typedef struct packed {
		logic        fifo_direct_access_en;
		logic        bus_mux_select;
		mem_mode_type memory_mode_select;
		logic [1:0]  latch_pulse_width_sel;
	} config_type;

	// cpu side request of one external move
	typedef struct packed {
		logic        start;
		logic        write;
		logic        short_addr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} move_req_type;

	// pin group: output and output enable (low drives)
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
	} pin_byte_type;

endpackage

// ===== rtl/ext_mem_regs.sv
/*
 * register file of the external memory port: configuration and page
 * select registers behind the 8-bit special function register port.
 * assumes write and read strobes are synchronous to CLOCK.
 */
`timescale 1ns/1ns
`default_nettype none
module ext_mem_regs
	import ext_mem_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       wr,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] rdata,
	output var  config_type cfg,
	output var  logic [7:0] page
);

	typedef struct packed {
		logic [7:0] config_r;
		logic [7:0] page_r;
		logic [7:0] rdata_r;
	} regs_state_type;

	regs_state_type s_r;
	regs_state_type s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (wr && addr == CONFIG_ADDR)
			s_nxt.config_r = wdata & CONFIG_WMASK;
		if (wr && addr == PAGE_ADDR)
			s_nxt.page_r = wdata;
		case (addr)
			CONFIG_ADDR: s_nxt.rdata_r = s_nxt.config_r;
			PAGE_ADDR:   s_nxt.rdata_r = s_nxt.page_r;
			default:     s_nxt.rdata_r = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_r.config_r <= CONFIG_RESET;
			s_r.page_r   <= PAGE_RESET;
			s_r.rdata_r  <= 8'h00;
		end
		else
			s_r <= s_nxt;
	end

	assign rdata = s_r.rdata_r;
	assign page  = s_r.page_r;
	assign cfg.fifo_direct_access_en = s_r.config_r[FIFO_DA_BIT];
	assign cfg.bus_mux_select        = s_r.config_r[MUX_SEL_BIT];
	assign cfg.memory_mode_select    = mem_mode_type'(s_r.config_r[MODE_HI_BIT:MODE_LO_BIT]);
	assign cfg.latch_pulse_width_sel = s_r.config_r[ALE_HI_BIT:ALE_LO_BIT];

endmodule
`default_nettype wire

// ===== tb/ext_mem_if_asserts.sv
/* checker of the external memory port, on top ports only.
   assumes a bind onto ext_mem_if and one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module ext_mem_if_asserts
	import ext_mem_pkg::*;
(
	// clock and reset
	input wire logic         CLOCK,
	input wire logic         RSTN,
	// register and move side
	input wire logic [7:0]   SFR_ADDR,
	input wire logic [7:0]   SFR_RDATA,
	input wire move_req_type MOVE_REQ,
	input wire logic         MOVE_DONE,
	input wire logic         ROUTE_ONCHIP,
	input wire logic         ROUTE_FIFO,
	// pins
	input wire pin_byte_type P4_PIN,
	input wire pin_byte_type P1_PIN
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	// =====================================================
	// strobe decode
	wire logic rd_on = !P1_PIN.out[6] && !P1_PIN.oe_n[6];
	wire logic wr_on = !P1_PIN.out[7] && !P1_PIN.oe_n[7];
	wire logic ale_on = P1_PIN.out[3] && !P1_PIN.oe_n[3];
	wire logic own = P1_PIN.oe_n != 8'hff;
	sequence strobe_s;
		rd_on || wr_on;
	endsequence
	// =====================================================
	// properties
	chk_cfg_unused: assert property ($past(SFR_ADDR) == CONFIG_ADDR |->
		SFR_RDATA[7] == 1'b0 && SFR_RDATA[5] == 1'b0) else $error("unused bits set");
	chk_done_release: assert property (MOVE_DONE |->
		P1_PIN.oe_n == 8'hff && P4_PIN.oe_n == 8'hff) else $error("pins kept");
	chk_read_float: assert property (rd_on |-> P4_PIN.oe_n == 8'hff)
		else $error("data driven in read");
	chk_latch_addr: assert property (ale_on |-> P4_PIN.oe_n == 8'h00 &&
		P4_PIN.out == MOVE_REQ.addr[7:0]) else $error("low address missing");
	chk_latch_fall: assert property ($fell(ale_on) |->
		!(rd_on || wr_on) ##[1:10] strobe_s) else $error("no strobe after latch");
	chk_write_data: assert property (wr_on |-> P4_PIN.oe_n == 8'h00 &&
		P4_PIN.out == MOVE_REQ.wdata) else $error("write data missing");
	chk_sep_length: assert property ($rose(own) && !ale_on |-> ##5 MOVE_DONE)
		else $error("separate length");
	chk_mux_length: assert property ($rose(own) && ale_on |-> ##[7:13] MOVE_DONE)
		else $error("multiplexed length");
	chk_fifo_onchip: assert property (ROUTE_FIFO |-> ROUTE_ONCHIP)
		else $error("fifo not on-chip");
endmodule
`default_nettype wire

// ===== tb/ext_mem_sram_model.sv
/* off-chip memory with its address latch.
   assumes registered pins from ext_mem_if, bus style from the bench. */
`timescale 1ns/1ns
`default_nettype none
module ext_mem_sram_model
	import ext_mem_pkg::*;
(
	// clock and bus style
	input wire logic         clk,
	input wire logic         mux,
	// pins
	input wire pin_byte_type p4,
	input wire pin_byte_type p3,
	input wire pin_byte_type p2,
	input wire pin_byte_type p1,
	// data back and seen address
	output logic [7:0]       p4_in,
	output logic [15:0]      seen_addr,
	output logic [7:0]       seen_hi_oe_n
);
	logic [7:0] mem [0:65535];
	logic [7:0] lat = 8'h00;
	logic [7:0] held = 8'h00;
	logic [1:0] hold = 2'h0;
	// strobes taken from port 1 only
	wire logic rd = !p1.out[6] && !p1.oe_n[6];
	wire logic wr = !p1.out[7] && !p1.oe_n[7];
	wire logic [15:0] a = {p2.out | p2.oe_n, mux ? lat : p3.out};
	// =====================================================
	// latch and array
	always @(posedge clk)
	begin
		if (p1.out[3] && !p1.oe_n[3])
			lat <= p4.out;
		if (wr)
			mem[a] <= p4.out;
		if (rd || wr)
		begin
			seen_addr <= a;
			seen_hi_oe_n <= p2.oe_n;
		end
		if (rd)
		begin
			held <= mem[a];
			hold <= 2'h3;
		end
		else if (hold != 2'h0)
			hold <= hold - 2'h1;
	end
	// released lines hold the last read byte for three cycles, then show its inverse
	assign p4_in = rd ? mem[a] : (hold != 2'h0 ? held : ~held);
endmodule
`default_nettype wire

// ===== tb/tb_ext_mem_if.sv
/* testbench of ext_mem_if with the off-chip memory model.
   assumes package, design, checker and model compile first. */
`timescale 1ns/1ns
`default_nettype none
module tb_ext_mem_if
	import ext_mem_pkg::*;
;
	logic         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, mux = 1'b0;
	logic [7:0]   addr = 8'h00, wdata = 8'h00, rdata, mrdata, p4_in, seen_hi;
	logic [15:0]  seen;
	move_req_type req = '0;
	logic         done, onchip, fifo;
	pin_byte_type p4, p3, p2, p1;
	int           miscompares = 0, num_checks = 0;
	always #50 clk = ~clk;
	ext_mem_if ext_mem_if_i (.CLOCK(clk), .RSTN(rst_n), .SFR_WR(wr), .SFR_ADDR(addr),
		.SFR_WDATA(wdata), .SFR_RDATA(rdata), .MOVE_REQ(req), .MOVE_DONE(done),
		.MOVE_RDATA(mrdata), .ROUTE_ONCHIP(onchip), .ROUTE_FIFO(fifo), .P4_IN(p4_in),
		.P4_PIN(p4), .P3_PIN(p3), .P2_PIN(p2), .P1_PIN(p1));
	ext_mem_sram_model ext_mem_sram_model_i (.clk(clk), .mux(mux), .p4(p4), .p3(p3),
		.p2(p2), .p1(p1), .p4_in(p4_in), .seen_addr(seen), .seen_hi_oe_n(seen_hi));
	// =====================================================
	// bus tasks
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rwr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk) wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		@(negedge clk) cmp(16'(rdata), 16'(exp));
	endtask
	task automatic mv(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d,
		output int n);
		req = '{1'b1, w, s, a, d};
		n = 0;
		do @(negedge clk) n++; while (done !== 1'b1 && n < 60);
		cmp(16'(done), 16'h0001);
		req.start = 1'b0;
		@(negedge clk);
	endtask
	// =====================================================
	// scenarios
	task automatic t_regs;
		rchk(CONFIG_ADDR, 8'h03);
		rchk(PAGE_ADDR, 8'h00);
		rwr(CONFIG_ADDR, 8'hff);
		rchk(CONFIG_ADDR, 8'h5f);
		rwr(PAGE_ADDR, 8'ha5);
		rchk(PAGE_ADDR, 8'ha5);
		rchk(8'h84, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_sep;
		int n;
		mux = 1'b0;
		rwr(CONFIG_ADDR, 8'h1c);
		mv(1'b1, 1'b0, 16'h0123, 8'h5a, n);
		cmp(16'(n), 16'd6);
		cmp(seen, 16'h0123);
		mv(1'b0, 1'b0, 16'h0123, 8'h00, n);
		cmp(16'(mrdata), 16'h005a);
		$display("test separate done");
	endtask
	task automatic t_mux;
		int n;
		mux = 1'b1;
		for (int e = 0; e < 4; e++)
		begin
			rwr(CONFIG_ADDR, 8'h0c | 8'(e));
			mv(1'b1, 1'b0, 16'h2340 + 16'(e), 8'hc0 + 8'(e), n);
			cmp(16'(n), 16'(6 + 2 * (e + 1)));
			mv(1'b0, 1'b0, 16'h2340 + 16'(e), 8'h00, n);
			cmp(16'(mrdata), 16'h00c0 + 16'(e));
		end
		$display("test multiplexed done");
	endtask
	task automatic t_page;
		int n;
		mux = 1'b0;
		rwr(PAGE_ADDR, 8'h12);
		rwr(CONFIG_ADDR, 8'h18);
		mv(1'b1, 1'b1, 16'h0034, 8'h77, n);
		cmp(seen, 16'h1234);
		cmp(16'(seen_hi), 16'h0000);
		rwr(CONFIG_ADDR, 8'h14);
		mv(1'b1, 1'b1, 16'h0056, 8'h78, n);
		cmp(16'(seen_hi), 16'h00ff);
		$display("test page done");
	endtask
	task automatic t_route;
		int n;
		for (int m = 0; m < 4; m++)
		begin
			rwr(CONFIG_ADDR, 8'h10 | 8'(m << 2));
			mv(1'b1, 1'b0, 16'h0100, 8'h01, n);
			cmp(16'(onchip), 16'(m != 3));
			mv(1'b1, 1'b0, 16'h2000, 8'h02, n);
			cmp(16'(onchip), 16'(m == 0));
		end
		rwr(CONFIG_ADDR, 8'h5c);
		mv(1'b1, 1'b0, 16'h07ff, 8'h03, n);
		cmp(16'(fifo), 16'h0001);
		mv(1'b1, 1'b0, 16'h0800, 8'h04, n);
		cmp(16'(fifo), 16'h0000);
		$display("test route done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_regs;
		t_sep;
		t_mux;
		t_page;
		t_route;
		summarize;
	end
	initial
	begin
		#(3000 * 100);
		miscompares++;
		summarize;
	end
endmodule
bind ext_mem_if ext_mem_if_asserts ext_mem_if_asserts_i (.CLOCK, .RSTN, .SFR_ADDR,
	.SFR_RDATA, .MOVE_REQ, .MOVE_DONE, .ROUTE_ONCHIP, .ROUTE_FIFO, .P4_PIN, .P1_PIN);
`default_nettype wire
